// File: hw/ipl_pkg.sv
// package: register map, field layout, reset values and carrier types for the priority bank
package ipl_pkg;

  localparam int IPL_NUM_REGS = 3;
  localparam int IPL_NUM_SRC = 24;
  localparam int IPL_AW = 8;

  // printed offsets 0x6 and 0x7 are not word multiples: kept as indices, byte address = 4 * index
  localparam logic [IPL_AW-1:0] IPL_IDX_TIMER_CD_DECODER = 8'h06;
  localparam logic [IPL_AW-1:0] IPL_IDX_TIMER_AB_C = 8'h07;
  localparam logic [IPL_AW-1:0] IPL_IDX_SERIAL0_TIMER_A = 8'h08;

  localparam logic [15:0] IPL_RST_TIMER_CD_DECODER = 16'h0000;
  localparam logic [15:0] IPL_RST_TIMER_AB_C = 16'h0000;
  localparam logic [15:0] IPL_RST_SERIAL0_TIMER_A = 16'h0000;

  // writable bit masks; unused pairs stay zero
  localparam logic [15:0] IPL_MASK_TIMER_CD_DECODER = 16'hFFCF;
  localparam logic [15:0] IPL_MASK_TIMER_AB_C = 16'hFFFF;
  localparam logic [15:0] IPL_MASK_SERIAL0_TIMER_A = 16'hF3FF;

  // field encoding
  localparam logic [1:0] IPL_FIELD_MASKED = 2'h0;
  localparam logic [1:0] IPL_FIELD_LEVEL0 = 2'h1;
  localparam logic [1:0] IPL_FIELD_LEVEL1 = 2'h2;
  localparam logic [1:0] IPL_FIELD_LEVEL2 = 2'h3;

  localparam logic [1:0] IPL_RESP_OKAY = 2'h0;
  localparam logic [1:0] IPL_RESP_SLVERR = 2'h2;

  // source index = (register slot * 8) + (field position / 2), slot 0 = timer_cd_decoder
  localparam int IPL_SRC_POS_DECODER0_HOME_WDOG = 0;
  localparam int IPL_SRC_POS_DECODER0_INDEX = 1;
  localparam int IPL_SRC_TIMER_D_CH0 = 3;
  localparam int IPL_SRC_TIMER_D_CH1 = 4;
  localparam int IPL_SRC_TIMER_D_CH2 = 5;
  localparam int IPL_SRC_TIMER_D_CH3 = 6;
  localparam int IPL_SRC_TIMER_C_CH0 = 7;
  localparam int IPL_SRC_TIMER_C_CH1 = 8;
  localparam int IPL_SRC_TIMER_C_CH2 = 9;
  localparam int IPL_SRC_TIMER_C_CH3 = 10;
  localparam int IPL_SRC_TIMER_B_CH0 = 11;
  localparam int IPL_SRC_TIMER_B_CH1 = 12;
  localparam int IPL_SRC_TIMER_B_CH2 = 13;
  localparam int IPL_SRC_TIMER_B_CH3 = 14;
  localparam int IPL_SRC_TIMER_A_CH0 = 15;
  localparam int IPL_SRC_TIMER_A_CH1 = 16;
  localparam int IPL_SRC_TIMER_A_CH2 = 17;
  localparam int IPL_SRC_TIMER_A_CH3 = 18;
  localparam int IPL_SRC_SERIAL0_TX_EMPTY = 19;
  localparam int IPL_SRC_SERIAL0_TX_IDLE = 20;
  localparam int IPL_SRC_SERIAL0_RX_ERROR = 22;
  localparam int IPL_SRC_SERIAL0_RX_FULL = 23;

  typedef struct packed {
    logic enable;
    logic [1:0] level;
  } ipl_src_level_t;

  typedef struct packed {
    logic [IPL_AW-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } ipl_wr_req_t;

endpackage : ipl_pkg

// File: hw/ipl_level_decode.sv
// per-source decode of a 2-bit priority field into enable and level
`timescale 1ns/1ps
`default_nettype none
module ipl_level_decode (
  input wire logic [1:0] field,
  output ipl_pkg::ipl_src_level_t result
);
  import ipl_pkg::*;

  always_comb begin
    result.enable = 1'b0;
    result.level = 2'h0;
    case (field)
      IPL_FIELD_LEVEL0: begin
        result.enable = 1'b1;
        result.level = 2'h0;
      end
      IPL_FIELD_LEVEL1: begin
        result.enable = 1'b1;
        result.level = 2'h1;
      end
      IPL_FIELD_LEVEL2: begin
        result.enable = 1'b1;
        result.level = 2'h2;
      end
      default: begin
        result.enable = 1'b0;
        result.level = 2'h0;
      end
    endcase
  end

endmodule : ipl_level_decode
`default_nettype wire

// File: hw/ipl_reg16.sv
// one 16-bit priority register with a fixed writable mask
`timescale 1ns/1ps
`default_nettype none
module ipl_reg16 #(
  parameter logic [15:0] RST = 16'h0000,
  parameter logic [15:0] MASK = 16'hFFFF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic [15:0] wdata,
  input wire logic [1:0] wstrb,
  output logic [15:0] value
);
  import ipl_pkg::*;

  logic [15:0] value_q;
  logic [15:0] lane;

  assign lane = {{8{wstrb[1]}}, {8{wstrb[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_q <= RST;
    end else if (we) begin
      value_q <= ((wdata & lane) | (value_q & ~lane)) & MASK;
    end
  end

  assign value = value_q;

endmodule : ipl_reg16
`default_nettype wire

// File: hw/ipl_priority_bank.sv
// top: axi4-lite slave holding the three priority registers and per-source level outputs
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// How it works
// - fields give masked or levels 0 to 2
// - 00 masked, 01/10/11 levels 0/1/2
// - reset clears all fields to masked
// - unused pairs read zero, ignore writes
// - first register 15:14 timer C channel 0
// - first register 13:12 D3, 11:10 D2
// - first register 9:8 D1, 7:6 D0
// - first register 3:2 index, 1:0 home/watchdog
// - second register 15:14 timer A channel 0
// - second register 13:6 timer B channels 3..0
// - second register 5:0 timer C channels 3..1
// - third register 15:14 rx full, 13:12 rx error
// - third register 9:8 tx idle, 7:6 tx empty
// - third register 5:4 A3, 3:2 A2
// - third register 1:0 A1, same encoding
module ipl_priority_bank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ipl_pkg::IPL_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ipl_pkg::IPL_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output ipl_pkg::ipl_src_level_t [ipl_pkg::IPL_NUM_SRC-1:0] src_level
);
  import ipl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // write channel capture

  logic aw_full_q;
  logic w_full_q;
  ipl_wr_req_t wr_q;
  logic [IPL_AW-1:0] wr_idx;
  logic wr_fire;
  logic [IPL_NUM_REGS-1:0] reg_we;
  logic wr_hit;

  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = !w_full_q && !s_axi_bvalid;
  assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      wr_q.addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_q <= 1'b1;
      wr_q.addr <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_q <= 1'b0;
      wr_q.data <= '0;
      wr_q.strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_q <= 1'b1;
      wr_q.data <= s_axi_wdata;
      wr_q.strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  assign wr_idx = {2'h0, wr_q.addr[IPL_AW-1:2]};

  always_comb begin
    reg_we = '0;
    wr_hit = 1'b0;
    if (wr_q.addr[1:0] != 2'h0) begin
      wr_hit = 1'b0;
    end else if (wr_idx == IPL_IDX_TIMER_CD_DECODER) begin
      reg_we[0] = wr_fire;
      wr_hit = 1'b1;
    end else if (wr_idx == IPL_IDX_TIMER_AB_C) begin
      reg_we[1] = wr_fire;
      wr_hit = 1'b1;
    end else if (wr_idx == IPL_IDX_SERIAL0_TIMER_A) begin
      reg_we[2] = wr_fire;
      wr_hit = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= IPL_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? IPL_RESP_OKAY : IPL_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // register bank

  logic [15:0] reg_val [IPL_NUM_REGS];
  logic [15:0] bank_flat [IPL_NUM_REGS];

  ipl_reg16 #(
    .RST(IPL_RST_TIMER_CD_DECODER),
    .MASK(IPL_MASK_TIMER_CD_DECODER)
  ) u_timer_cd_decoder (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(reg_we[0]),
    .wdata(wr_q.data[15:0]),
    .wstrb(wr_q.strb[1:0]),
    .value(reg_val[0])
  );

  ipl_reg16 #(
    .RST(IPL_RST_TIMER_AB_C),
    .MASK(IPL_MASK_TIMER_AB_C)
  ) u_timer_ab_c (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(reg_we[1]),
    .wdata(wr_q.data[15:0]),
    .wstrb(wr_q.strb[1:0]),
    .value(reg_val[1])
  );

  ipl_reg16 #(
    .RST(IPL_RST_SERIAL0_TIMER_A),
    .MASK(IPL_MASK_SERIAL0_TIMER_A)
  ) u_serial0_timer_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(reg_we[2]),
    .wdata(wr_q.data[15:0]),
    .wstrb(wr_q.strb[1:0]),
    .value(reg_val[2])
  );

  // field slots: slot k of register r is source r*8+k, bits 2k+1:2k
  // timer_cd_decoder: C0 D3 D2 D1 D0 - index home
  // timer_ab_c: A0 B3 B2 B1 B0 C3 C2 C1
  // serial0_timer_a: rxfull rxerr - txidle txempty A3 A2 A1
  always_comb begin
    bank_flat[0] = reg_val[0];
    bank_flat[1] = reg_val[1];
    bank_flat[2] = reg_val[2];
  end

  //////////////////////////////////////////////////////////////////////////////
  // decoded levels toward the arbiter

  genvar gi;
  generate
    for (gi = 0; gi < IPL_NUM_SRC; gi++) begin : g_src
      ipl_src_level_t dec;
      ipl_level_decode u_dec (
        .field(bank_flat[gi / 8][2 * (gi % 8) +: 2]),
        .result(dec)
      );
      assign src_level[gi] = dec;
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // read channel

  logic [IPL_AW-1:0] rd_idx;
  logic [31:0] rd_data;
  logic rd_hit;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx = {2'h0, s_axi_araddr[IPL_AW-1:2]};

  always_comb begin
    rd_data = '0;
    rd_hit = 1'b0;
    if (s_axi_araddr[1:0] != 2'h0) begin
      rd_hit = 1'b0;
    end else if (rd_idx == IPL_IDX_TIMER_CD_DECODER) begin
      rd_data = {16'h0000, reg_val[0]};
      rd_hit = 1'b1;
    end else if (rd_idx == IPL_IDX_TIMER_AB_C) begin
      rd_data = {16'h0000, reg_val[1]};
      rd_hit = 1'b1;
    end else if (rd_idx == IPL_IDX_SERIAL0_TIMER_A) begin
      rd_data = {16'h0000, reg_val[2]};
      rd_hit = 1'b1;
    end
  end

  // reads change no state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= IPL_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? IPL_RESP_OKAY : IPL_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : ipl_priority_bank
`default_nettype wire

// File: sim/ipl_arb_model.sv
// partner model: arbiter that consumes the per-source priority levels
`timescale 1ns/1ps
`default_nettype none
module ipl_arb_model (
  input wire ipl_pkg::ipl_src_level_t [ipl_pkg::IPL_NUM_SRC-1:0] src_level,
  output logic any_req,
  output logic [1:0] top_lvl
);
  import ipl_pkg::*;
  // masked sources never raise a request; highest level wins
  always_comb begin
    any_req = 1'b0;
    top_lvl = 2'h0;
    for (int k = 0; k < IPL_NUM_SRC; k++) begin
      if (src_level[k].enable) begin
        any_req = 1'b1;
        if (src_level[k].level > top_lvl) top_lvl = src_level[k].level;
      end
    end
  end
endmodule : ipl_arb_model
`default_nettype wire

// File: sim/ipl_priority_bank_chk.sv
// checker: reset, decode and bus timing relations of the priority bank
`timescale 1ns/1ps
`default_nettype none
module ipl_priority_bank_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ipl_pkg::IPL_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire ipl_pkg::ipl_src_level_t [ipl_pkg::IPL_NUM_SRC-1:0] src_level
);
  import ipl_pkg::*;
  logic [IPL_AW-1:0] ar_q;
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence r_held; s_axi_rvalid && !s_axi_rready; endsequence
  a_rst_clear: assert property (disable iff (1'b0) !aresetn |=> src_level == '0)
    else $error("levels not cleared by reset");
  a_unused_off: assert property (!src_level[2].enable && !src_level[21].enable)
    else $error("unused pair enabled");
  a_read_lat: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_hold: assert property (r_held |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  a_rsv_zero: assert property (s_axi_rvalid |->
    !(ar_q == 8'h18 && s_axi_rdata[5:4] != 2'h0)
    && !(ar_q == 8'h20 && s_axi_rdata[11:10] != 2'h0))
    else $error("reserved pair not zero");
  a_src_stable: assert property ($past(aresetn) && !$rose(s_axi_bvalid) |-> $stable(src_level))
    else $error("levels moved without write");
  for (genvar k = 0; k < IPL_NUM_SRC; k++) begin : g_src
    a_level_range: assert property (src_level[k].level != 2'h3
      && (src_level[k].enable || src_level[k].level == 2'h0))
      else $error("level out of range");
  end
endmodule : ipl_priority_bank_chk
`default_nettype wire

// File: sim/ipl_priority_bank_test.sv
// testbench: register access, field decode and reset of the priority bank
`timescale 1ns/1ps
`default_nettype none
module ipl_priority_bank_test;
  import ipl_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [IPL_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, any_req;
  logic [1:0] s_axi_bresp, s_axi_rresp, top_lvl;
  ipl_src_level_t [IPL_NUM_SRC-1:0] src_level;
  logic [15:0] sh [3];
  logic [15:0] msk [3] = '{16'hFFCF, 16'hFFFF, 16'hF3FF};
  int n_fail = 0, compares = 0, cyc = 0;
  always #50 aclk = ~aclk;
  ipl_priority_bank i_ipl_priority_bank (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .src_level);
  ipl_arb_model i_ipl_arb_model (.src_level, .any_req, .top_lvl);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {16'h0000, e}, "rdata");
    chk({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
  endtask : rd
  task automatic chk_src();
    logic [1:0] f;
    for (int k = 0; k < IPL_NUM_SRC; k++) begin
      f = sh[k / 8][(k % 8) * 2 +: 2];
      chk({29'h0, src_level[k]}, {29'h0, f != 2'h0, f - (f != 2'h0)}, "level");
    end
  endtask : chk_src
  task automatic t_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      sh[i] = 16'h0000;
      rd(8'h18 + 8'(4 * i), 16'h0000, 2'h0);
    end
    chk_src();
    chk({31'h0, any_req}, 32'h0, "idle request");
    $display("test reset done");
  endtask : t_reset
  task automatic t_fields();
    logic [15:0] p [4] = '{16'hFFFF, 16'hE4E4, 16'h1B1B, 16'h0000};
    foreach (p[j]) begin
      for (int i = 0; i < 3; i++) begin
        wr(8'h18 + 8'(4 * i), p[j], 4'h3, 2'h0);
        sh[i] = p[j] & msk[i];
        rd(8'h18 + 8'(4 * i), sh[i], 2'h0);
      end
      chk_src();
      chk({30'h0, top_lvl}, (p[j] != 16'h0000) ? 32'h2 : 32'h0, "top level");
      chk({31'h0, any_req}, {31'h0, p[j] != 16'h0000}, "any request");
    end
    $display("test fields done");
  endtask : t_fields
  task automatic t_bus();
    wr(8'h1C, 16'h9696, 4'h3, 2'h0);
    wr(8'h1C, 16'h5A5A, 4'h1, 2'h0);
    sh[1] = 16'h965A;
    rd(8'h1C, sh[1], 2'h0);
    wr(8'h1C, 16'h3C3C, 4'h2, 2'h0);
    sh[1] = 16'h3C5A;
    rd(8'h1C, sh[1], 2'h0);
    wr(8'h00, 16'hFFFF, 4'h3, 2'h2);
    wr(8'h19, 16'hFFFF, 4'h3, 2'h2);
    rd(8'h24, 16'h0000, 2'h2);
    rd(8'h1B, 16'h0000, 2'h2);
    rd(8'h18, sh[0], 2'h0);
    chk_src();
    $display("test bus done");
  endtask : t_bus
  task automatic tally_and_finish();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    t_reset();
    t_fields();
    t_bus();
    t_reset();
    tally_and_finish();
  end
endmodule : ipl_priority_bank_test
bind ipl_priority_bank ipl_priority_bank_chk i_ipl_priority_bank_chk (.aclk, .aresetn,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .src_level);
`default_nettype wire
